// ==== verilog/dac_regs_pkg.sv ====
// Constants shared by the converter interrupt, status and data registers
package dac_regs_pkg;

  // ****************************************************************
  // Register indices; byte address is four times the index
  // ****************************************************************
  localparam logic [7:0] IDX_CONTROL_B     = 8'h01;
  localparam logic [7:0] IDX_EVENT_CTRL    = 8'h02;
  localparam logic [7:0] IDX_IRQ_EN_CLEAR  = 8'h04;
  localparam logic [7:0] IDX_IRQ_EN_SET    = 8'h05;
  localparam logic [7:0] IDX_IRQ_FLAGS     = 8'h06;
  localparam logic [7:0] IDX_SYNC_STATUS   = 8'h07;
  localparam logic [7:0] IDX_CONV_VALUE    = 8'h08;
  localparam logic [7:0] IDX_DATA_BUFFER   = 8'h0c;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_UNDERRUN    = 0;
  localparam int BIT_EMPTY       = 1;
  localparam int BIT_SYNC_READY  = 2;
  localparam int BIT_SYNC_BUSY   = 7;
  localparam int BIT_LEFT_ADJUST = 2;
  localparam int BIT_START_EI    = 0;
  localparam int BIT_EMPTY_EO    = 1;
  localparam int CODE_W          = 10;
  localparam int LEFT_LSB        = 6;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]  RST_CONTROL_B  = 8'h00;
  localparam logic [1:0]  RST_EVENT_CTRL = 2'h0;
  localparam logic [2:0]  RST_IRQ_EN     = 3'h0;
  localparam logic [2:0]  RST_IRQ_FLAGS  = 3'h0;
  localparam logic [15:0] RST_CONV_VALUE = 16'h0000;
  localparam logic [15:0] RST_DATA_BUF   = 16'h0000;

  // ****************************************************************
  // Timing: domain transfer takes this long at 100 MHz
  // ****************************************************************
  localparam int SYS_CLK_MHZ  = 100;
  localparam int SYNC_TIME_NS = 30;
  localparam int SYNC_CYCLES_INT = (SYNC_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] SYNC_CYCLES = SYNC_CYCLES_INT[3:0];

  typedef enum logic [0:0] {
    SYNC_IDLE = 1'b0,
    SYNC_RUN  = 1'b1
  } sync_state_t;

endpackage

// ==== verilog/sync_track_if.sv ====
// Handshake between the register file and the transfer tracker
`timescale 1ns/1ps
interface sync_track_if;
  logic start;
  logic busy;
  logic done;

  modport regs (output start, input busy, input done);
  modport track (input start, output busy, output done);
endinterface

// ==== verilog/sync_tracker.sv ====
// Tracks a register transfer between clock domains
`timescale 1ns/1ps
module sync_tracker (
  input  wire logic   i_sys_clk,
  input  wire logic   i_rstn,
  sync_track_if.track trk
);

  dac_regs_pkg::sync_state_t state_q;
  logic [3:0]                cnt_q;
  logic                      done_q;

  assign trk.busy = (state_q == dac_regs_pkg::SYNC_RUN);
  assign trk.done = done_q;

  // A start while running restarts the count so the newest write is covered
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= dac_regs_pkg::SYNC_IDLE;
      cnt_q   <= 4'h0;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        dac_regs_pkg::SYNC_IDLE: begin
          if (trk.start) begin
            state_q <= dac_regs_pkg::SYNC_RUN;
            cnt_q   <= dac_regs_pkg::SYNC_CYCLES;
          end
        end
        dac_regs_pkg::SYNC_RUN: begin
          if (trk.start) begin
            cnt_q <= dac_regs_pkg::SYNC_CYCLES;
          end else if (cnt_q == 4'h1) begin
            state_q <= dac_regs_pkg::SYNC_IDLE;
            done_q  <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
      endcase
    end
  end

endmodule // sync_tracker

// ==== verilog/dac_irq_status_data_regs.sv ====
// APB register file for converter interrupts, status and data words
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module dac_irq_status_data_regs (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic        i_start_evt,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_irq,
  output logic             o_empty_evt,
  output logic      [9:0]  o_conv_code,
  output logic             o_left_adjust
);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  wire         setup_phase = i_psel & ~i_penable;
  wire         access_done = i_psel & i_penable & pready_q;
  wire         wr_done     = access_done & i_pwrite;
  wire [9:0]   word_idx    = i_paddr[11:2];
  wire         aligned     = (i_paddr[1:0] == 2'b00);

  wire hit_control_b_register = aligned && (word_idx == {2'b00, dac_regs_pkg::IDX_CONTROL_B});
  wire hit_evctl = aligned && (word_idx == {2'b00, dac_regs_pkg::IDX_EVENT_CTRL});
  wire hit_enclr = aligned && (word_idx == {2'b00, dac_regs_pkg::IDX_IRQ_EN_CLEAR});
  wire hit_enset = aligned && (word_idx == {2'b00, dac_regs_pkg::IDX_IRQ_EN_SET});
  wire hit_flags = aligned && (word_idx == {2'b00, dac_regs_pkg::IDX_IRQ_FLAGS});
  wire hit_stat  = aligned && (word_idx == {2'b00, dac_regs_pkg::IDX_SYNC_STATUS});
  wire hit_data  = aligned && (word_idx == {2'b00, dac_regs_pkg::IDX_CONV_VALUE});
  wire hit_dbuf  = aligned && (word_idx == {2'b00, dac_regs_pkg::IDX_DATA_BUFFER});
  wire hit_any   = hit_control_b_register | hit_evctl | hit_enclr | hit_enset |
                   hit_flags | hit_stat | hit_data | hit_dbuf;

  // Status register is read-only; writing it is refused
  wire         bad_access = ~hit_any | (i_pwrite & hit_stat);

  wire wr_control_b_register = wr_done & hit_control_b_register;
  wire wr_evctl = wr_done & hit_evctl;
  wire wr_enclr = wr_done & hit_enclr;
  wire wr_enset = wr_done & hit_enset;
  wire wr_flags = wr_done & hit_flags;
  wire wr_data  = wr_done & hit_data;
  wire wr_dbuf  = wr_done & hit_dbuf;

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0]  control_b_register_q;
  logic [1:0]  evctl_q;
  logic [2:0]  irq_en_q;
  logic [2:0]  irq_flags_q;
  logic [15:0] conv_value_q;
  logic [15:0] data_buf_q;
  logic        buf_full_q;
  logic        empty_evt_q;
  logic [9:0]  conv_code_q;
  logic        irq_q;

  sync_track_if trk ();

  sync_tracker u_sync_tracker (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .trk       (trk)
  );

  // Writes of the value or buffer word cross to the converter domain
  assign trk.start = wr_data | wr_dbuf;

  // ****************************************************************
  // Event path
  // ****************************************************************
  wire left_adj  = control_b_register_q[dac_regs_pkg::BIT_LEFT_ADJUST];
  wire start_ei  = evctl_q[dac_regs_pkg::BIT_START_EI];
  wire empty_eo  = evctl_q[dac_regs_pkg::BIT_EMPTY_EO];
  wire start_hit = i_start_evt & start_ei;
  wire buf_move  = start_hit & buf_full_q;
  wire underrun  = start_hit & ~buf_full_q;

  // ****************************************************************
  // Enable vector, one store behind both set and clear views
  // ****************************************************************
  wire [2:0] wdata3  = i_pwdata[2:0];
  wire [2:0] en_set  = wr_enset ? wdata3 : 3'h0;
  wire [2:0] en_clr  = wr_enclr ? wdata3 : 3'h0;
  wire [2:0] en_d    = (irq_en_q & ~en_clr) | en_set;

  // ****************************************************************
  // Flags: hardware set wins over software clear
  // ****************************************************************
  logic [2:0] flag_set;
  logic [2:0] flag_clr;

  always_comb begin
    flag_set = 3'h0;
    flag_set[dac_regs_pkg::BIT_UNDERRUN]   = underrun;
    flag_set[dac_regs_pkg::BIT_EMPTY]      = buf_move;
    flag_set[dac_regs_pkg::BIT_SYNC_READY] = trk.done;
    flag_clr = wr_flags ? wdata3 : 3'h0;
    flag_clr[dac_regs_pkg::BIT_EMPTY] = flag_clr[dac_regs_pkg::BIT_EMPTY] | wr_dbuf;
  end

  wire [2:0] flags_d = (irq_flags_q & ~flag_clr) | flag_set;

  // ****************************************************************
  // Code extraction by alignment
  // ****************************************************************
  wire [15:0] value_d   = wr_data ? i_pwdata[15:0] :
                          (buf_move ? data_buf_q : conv_value_q);
  wire [9:0]  code_right = value_d[dac_regs_pkg::CODE_W-1:0];
  wire [9:0]  code_left  = value_d[dac_regs_pkg::LEFT_LSB +: dac_regs_pkg::CODE_W];
  wire        left_d     = wr_control_b_register ? i_pwdata[dac_regs_pkg::BIT_LEFT_ADJUST] : left_adj;
  wire [9:0]  code_d     = left_d ? code_left : code_right;

  // ****************************************************************
  // Read mux
  // ****************************************************************
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_control_b_register) begin
      rd_mux[7:0] = control_b_register_q;
    end
    if (hit_evctl) begin
      rd_mux[1:0] = evctl_q;
    end
    if (hit_enclr | hit_enset) begin
      rd_mux[2:0] = irq_en_q;
    end
    if (hit_flags) begin
      rd_mux[2:0] = irq_flags_q;
    end
    if (hit_stat) begin
      rd_mux[dac_regs_pkg::BIT_SYNC_BUSY] = trk.busy;
    end
  end

  // ****************************************************************
  // Bus handshake: no wait state, answer prepared at setup
  // ****************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup_phase) begin
      pready_q  <= 1'b1;
      prdata_q  <= i_pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_q <= bad_access;
    end else if (access_done) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Configuration and enables
  // ****************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      control_b_register_q  <= dac_regs_pkg::RST_CONTROL_B;
      evctl_q  <= dac_regs_pkg::RST_EVENT_CTRL;
      irq_en_q <= dac_regs_pkg::RST_IRQ_EN;
    end else begin
      if (wr_control_b_register) begin
        control_b_register_q <= i_pwdata[7:0];
      end
      if (wr_evctl) begin
        evctl_q <= i_pwdata[1:0];
      end
      irq_en_q <= en_d;
    end
  end

  // ****************************************************************
  // Flags, value and buffer
  // ****************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_flags_q  <= dac_regs_pkg::RST_IRQ_FLAGS;
      conv_value_q <= dac_regs_pkg::RST_CONV_VALUE;
      data_buf_q   <= dac_regs_pkg::RST_DATA_BUF;
      buf_full_q   <= 1'b0;
    end else begin
      irq_flags_q  <= flags_d;
      conv_value_q <= value_d;
      if (wr_dbuf) begin
        data_buf_q <= i_pwdata[15:0];
        buf_full_q <= 1'b1;
      end else if (buf_move) begin
        buf_full_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      empty_evt_q <= 1'b0;
      conv_code_q <= 10'h000;
      irq_q       <= 1'b0;
    end else begin
      empty_evt_q <= buf_move & empty_eo;
      conv_code_q <= code_d;
      irq_q       <= |(flags_d & en_d);
    end
  end

  assign o_prdata      = prdata_q;
  assign o_pready      = pready_q;
  assign o_pslverr     = pslverr_q;
  assign o_irq         = irq_q;
  assign o_empty_evt   = empty_evt_q;
  assign o_conv_code   = conv_code_q;
  assign o_left_adjust = control_b_register_q[dac_regs_pkg::BIT_LEFT_ADJUST];

endmodule // dac_irq_status_data_regs

// ==== test/dac_irq_status_data_regs_props.sv ====
// Port-level checker for the converter interrupt, status and data registers
`timescale 1ns/1ps
module dac_irq_status_data_regs_props (
  input wire logic        i_sys_clk,
  input wire logic        i_rstn,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        i_start_evt,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_irq,
  input wire logic        o_empty_evt,
  input wire logic [9:0]  o_conv_code,
  input wire logic        o_left_adjust
);
  localparam logic [11:0] A_VAL  = {2'h0, dac_regs_pkg::IDX_CONV_VALUE, 2'h0};
  localparam logic [11:0] A_BUF  = {2'h0, dac_regs_pkg::IDX_DATA_BUFFER, 2'h0};
  localparam logic [11:0] A_STAT = {2'h0, dac_regs_pkg::IDX_SYNC_STATUS, 2'h0};
  localparam logic [11:0] A_SET  = {2'h0, dac_regs_pkg::IDX_IRQ_EN_SET, 2'h0};
  logic wr_done;
  logic rd_done;
  assign wr_done = i_psel & i_penable & o_pready & i_pwrite;
  assign rd_done = i_psel & i_penable & o_pready & ~i_pwrite;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  AST_EMPTY_EVT_PULSE: assert property (o_empty_evt |=> !o_empty_evt)
    else $error("empty event longer than one cycle");
  // Event, code and adjust are registered one edge after their cause
  AST_EMPTY_EVT_CAUSE: assert property (o_empty_evt |->
    $past(i_start_evt))
    else $error("empty event without start event");
  AST_CODE_CAUSE: assert property (!$stable(o_conv_code) |->
    ($past(wr_done) || $past(i_start_evt)))
    else $error("code changed without write or start event");
  AST_ADJ_CAUSE: assert property (!$stable(o_left_adjust) |->
    $past(wr_done))
    else $error("adjust select changed without write");
  AST_WO_READ_ZERO: assert property (rd_done && (i_paddr == A_VAL || i_paddr == A_BUF)
    |-> o_prdata == 32'h0 && !o_pslverr)
    else $error("write-only register read not zero");
  AST_STATUS_RO: assert property (wr_done && i_paddr == A_STAT |-> o_pslverr)
    else $error("status write not refused");
  AST_STATUS_BITS: assert property (rd_done && i_paddr == A_STAT |->
    o_prdata[6:0] == 7'h0 && o_prdata[31:8] == 24'h0)
    else $error("status reserved bits set");
  AST_EN_WIDTH: assert property (rd_done && i_paddr == A_SET |-> o_prdata[31:3] == 29'h0)
    else $error("enable read has bits above 2");
endmodule // dac_irq_status_data_regs_props

bind dac_irq_status_data_regs dac_irq_status_data_regs_props u_props (
  .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_start_evt(i_start_evt),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq),
  .o_empty_evt(o_empty_evt), .o_conv_code(o_conv_code), .o_left_adjust(o_left_adjust));

// ==== test/dac_irq_status_data_regs_bench.sv ====
// Self-checking bench for the converter interrupt, status and data registers
`timescale 1ns/1ps
module dac_irq_status_data_regs_bench;
  logic        i_sys_clk   = 1'b0;
  logic        i_rstn      = 1'b0;
  logic        i_psel      = 1'b0;
  logic        i_penable   = 1'b0;
  logic        i_pwrite    = 1'b0;
  logic [11:0] i_paddr     = 12'h0;
  logic [31:0] i_pwdata    = 32'h0;
  logic        i_start_evt = 1'b0;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic        o_irq;
  logic        o_empty_evt;
  logic [9:0]  o_conv_code;
  logic        o_left_adjust;
  int          n_mismatch  = 0;
  int          checked     = 0;
  int          evts;
  logic [31:0] rdata;
  logic        err;
  // Enable walk: register written, value, vector expected after it
  logic [7:0]  t_idx [6] = '{dac_regs_pkg::IDX_IRQ_EN_SET, dac_regs_pkg::IDX_IRQ_EN_CLEAR,
    dac_regs_pkg::IDX_IRQ_EN_CLEAR, dac_regs_pkg::IDX_IRQ_EN_CLEAR,
    dac_regs_pkg::IDX_IRQ_EN_SET, dac_regs_pkg::IDX_IRQ_EN_SET};
  logic [31:0] t_dat [6] = '{32'h7, 32'h0, 32'h2, 32'h1, 32'h0, 32'h2};
  logic [31:0] t_exp [6] = '{32'h7, 32'h7, 32'h5, 32'h4, 32'h4, 32'h6};

  always #5 i_sys_clk = ~i_sys_clk;

  dac_irq_status_data_regs uut (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_start_evt(i_start_evt),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq),
    .o_empty_evt(o_empty_evt), .o_conv_code(o_conv_code), .o_left_adjust(o_left_adjust));

  task automatic close_out();
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Leaves psel high so a following call is back to back; idle() releases it
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= {2'h0, idx, 2'h0};
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (o_pready !== 1'b1) begin
      n_mismatch++;
      close_out();
    end
    rdata = o_prdata;
    err = o_pslverr;
    i_penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, idx, 32'h0);
    chk($sformatf("reg %h", idx), exp, rdata & m);
  endtask

  task automatic idle(input int k);
    i_psel <= 1'b0;
    repeat (k) @(posedge i_sys_clk);
  endtask

  task automatic pulse();
    evts = 0;
    i_psel <= 1'b0;
    i_start_evt <= 1'b1;
    @(posedge i_sys_clk);
    i_start_evt <= 1'b0;
    repeat (4) begin
      @(posedge i_sys_clk);
      if (o_empty_evt === 1'b1) evts++;
    end
  endtask

  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    rd(dac_regs_pkg::IDX_IRQ_EN_SET, 32'h0, '1);
    rd(dac_regs_pkg::IDX_IRQ_FLAGS, 32'h0, '1);
    rd(dac_regs_pkg::IDX_SYNC_STATUS, 32'h0, '1);
    rd(dac_regs_pkg::IDX_CONV_VALUE, 32'h0, '1);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, t_idx[i], t_dat[i]);
      rd(t_idx[i] ^ 8'h01, t_exp[i], '1);
    end
    apb(1'b1, dac_regs_pkg::IDX_IRQ_EN_CLEAR, 32'h2);
    apb(1'b1, dac_regs_pkg::IDX_CONV_VALUE, 32'h0000_fd55);
    rd(dac_regs_pkg::IDX_SYNC_STATUS, 32'h80, '1);
    idle(6);
    rd(dac_regs_pkg::IDX_SYNC_STATUS, 32'h0, '1);
    rd(dac_regs_pkg::IDX_IRQ_FLAGS, 32'h4, '1);
    idle(2);
    chk("code", 32'h155, {22'h0, o_conv_code});
    chk("irq", 32'h1, {31'h0, o_irq});
    apb(1'b1, dac_regs_pkg::IDX_IRQ_FLAGS, 32'h4);
    idle(3);
    chk("irq", 32'h0, {31'h0, o_irq});
    apb(1'b1, dac_regs_pkg::IDX_SYNC_STATUS, 32'hff);
    chk("status err", 32'h1, {31'h0, err});
    apb(1'b1, 8'h03, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b1, dac_regs_pkg::IDX_EVENT_CTRL, 32'h3);
    apb(1'b1, dac_regs_pkg::IDX_IRQ_EN_SET, 32'h1);
    pulse();
    rd(dac_regs_pkg::IDX_IRQ_FLAGS, 32'h1, '1);
    idle(2);
    chk("irq", 32'h1, {31'h0, o_irq});
    apb(1'b1, dac_regs_pkg::IDX_IRQ_FLAGS, 32'h0);
    rd(dac_regs_pkg::IDX_IRQ_FLAGS, 32'h1, '1);
    apb(1'b1, dac_regs_pkg::IDX_IRQ_FLAGS, 32'h1);
    rd(dac_regs_pkg::IDX_IRQ_FLAGS, 32'h0, '1);
    apb(1'b1, dac_regs_pkg::IDX_CONTROL_B, 32'h4);
    apb(1'b1, dac_regs_pkg::IDX_DATA_BUFFER, 32'h0000_a940);
    apb(1'b1, dac_regs_pkg::IDX_IRQ_EN_SET, 32'h2);
    idle(2);
    chk("adjust", 32'h1, {31'h0, o_left_adjust});
    chk("code", 32'h3f5, {22'h0, o_conv_code});
    pulse();
    chk("empty events", 32'h1, evts);
    chk("code", 32'h2a5, {22'h0, o_conv_code});
    rd(dac_regs_pkg::IDX_IRQ_FLAGS, 32'h2, 32'h3);
    idle(2);
    chk("irq", 32'h1, {31'h0, o_irq});
    apb(1'b1, dac_regs_pkg::IDX_DATA_BUFFER, 32'h0000_0040);
    rd(dac_regs_pkg::IDX_IRQ_FLAGS, 32'h0, 32'h2);
    // Start input on, empty event output off: move happens, no event
    apb(1'b1, dac_regs_pkg::IDX_EVENT_CTRL, 32'h1);
    pulse();
    chk("empty events", 32'h0, evts);
    chk("code", 32'h001, {22'h0, o_conv_code});
    rd(dac_regs_pkg::IDX_IRQ_FLAGS, 32'h2, 32'h2);
    apb(1'b1, dac_regs_pkg::IDX_IRQ_FLAGS, 32'h2);
    rd(dac_regs_pkg::IDX_IRQ_FLAGS, 32'h0, 32'h2);
    // Start input off: an event on the empty buffer is ignored
    apb(1'b1, dac_regs_pkg::IDX_EVENT_CTRL, 32'h0);
    pulse();
    rd(dac_regs_pkg::IDX_IRQ_FLAGS, 32'h0, 32'h3);
    chk("code", 32'h001, {22'h0, o_conv_code});
    apb(1'b1, dac_regs_pkg::IDX_IRQ_EN_CLEAR, 32'h7);
    idle(8);
    chk("irq", 32'h0, {31'h0, o_irq});
    close_out();
  end
endmodule // dac_irq_status_data_regs_bench
